// >>> rtl/sfo_exec.v
// Execution unit for software interrupt, OR and special-page store
`include "sfo_regs.vh"
module sfo_exec #(
  parameter STACK_DEPTH = 8,
  parameter STACK_PTR_W = 3
) (
  clk,
  reset,
  op_valid,
  op_sel,
  op_literal,
  op_file_addr,
  op_dest,
  op_spr_addr,
  file_rdata,
  op_ready,
  program_counter,
  accumulator,
  zero_flag,
  file_we,
  file_waddr,
  file_wdata,
  spr_we,
  spr_addr,
  spr_wdata,
  stack_top,
  stack_level
);
  input wire clk;
  input wire reset;
  input wire op_valid;
  input wire [2:0] op_sel;
  input wire [7:0] op_literal;
  input wire [`SFO_FILE_AW-1:0] op_file_addr;
  input wire op_dest;
  input wire [`SFO_SPR_AW-1:0] op_spr_addr;
  input wire [7:0] file_rdata;
  output wire op_ready;
  output reg [`SFO_PC_W-1:0] program_counter;
  output reg [7:0] accumulator;
  output reg zero_flag;
  output reg file_we;
  output reg [`SFO_FILE_AW-1:0] file_waddr;
  output reg [7:0] file_wdata;
  output reg spr_we;
  output reg [`SFO_SPR_AW-1:0] spr_addr;
  output reg [7:0] spr_wdata;
  output wire [`SFO_PC_W-1:0] stack_top;
  output wire [STACK_PTR_W-1:0] stack_level;

  // ==========================================================
  // Sequence states
  // The software interrupt is the only multi-cycle op; every
  // other op retires from the idle state in the cycle it is taken
  localparam ST_IDLE = 2'b00; // Ready for a new op
  localparam ST_PUSH = 2'b01; // Return address goes onto the stack
  localparam ST_VECT = 2'b10; // Program counter jumps to the vector

  // ==========================================================
  // Internal signals
  reg [1:0] state_r; // Sequence state
  reg [1:0] state_nxt; // Next sequence state
  reg stack_push_r; // One-cycle push strobe
  wire [7:0] or_src; // Second OR operand
  wire [7:0] or_res; // OR result
  wire [`SFO_PC_W-1:0] pc_inc; // Address of the following instruction
  wire take; // Operation accepted this cycle
  wire take_swint; // Software interrupt accepted
  wire take_or_imm; // Immediate OR accepted
  wire take_or_reg; // Register OR accepted
  wire take_store; // Special-page store accepted

  // ==========================================================
  // Helper functions
  // Zero test shared by both OR forms
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == `SFO_ZERO_BYTE);
    end
  endfunction

  // Step to the following instruction; wraps at the top of the
  // ten-bit space like a plain counter, which callers must expect
  function [`SFO_PC_W-1:0] pc_plus_one;
    input [`SFO_PC_W-1:0] pc;
    begin
      pc_plus_one = pc + {{(`SFO_PC_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Match of the op code against one encoding
  function op_is;
    input [2:0] sel;
    input [2:0] code;
    begin
      op_is = (sel == code);
    end
  endfunction

  // ==========================================================
  // Operand selection and decode
  // New ops are held off while the interrupt sequence runs, so
  // the decode path must keep op_valid up until op_ready is seen
  assign op_ready = (state_r == ST_IDLE);
  assign take = op_valid && op_ready;
  assign take_swint = take && op_is(op_sel, `SFO_OP_SWINT);
  assign take_or_imm = take && op_is(op_sel, `SFO_OP_OR_IMM);
  assign take_or_reg = take && op_is(op_sel, `SFO_OP_OR_REG);
  assign take_store = take && op_is(op_sel, `SFO_OP_SP_STORE);
  // The file read port is combinational, so the register form
  // sees R in the same cycle as the literal form sees its byte
  assign or_src = op_is(op_sel, `SFO_OP_OR_IMM) ? op_literal : file_rdata;
  assign or_res = accumulator | or_src;
  // Program counter has not moved yet when the push strobe fires
  assign pc_inc = pc_plus_one(program_counter);

  // ==========================================================
  // Return stack
  // Depth and overflow are the stack's business; this unit only
  // ever pushes, and returns are handled by other instructions
  sfo_return_stack #(
    .DEPTH(STACK_DEPTH),
    .PTR_W(STACK_PTR_W)
  ) u_stack (
    .clk(clk),
    .reset(reset),
    .push(stack_push_r),
    .push_addr(pc_inc),
    .top_addr(stack_top),
    .level(stack_level)
  );

  // ==========================================================
  // Sequence next state
  // Three cycles from acceptance to the vector: take, push, load
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_swint) begin
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // Second cycle: stack write lands, flags stay
        state_nxt = ST_VECT;
      end
      ST_VECT: begin
        // Third cycle ends the sequence
        state_nxt = ST_IDLE;
      end
      default: begin
        // Unused code: fall back to idle rather than lock up
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Sequence state register
  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Execution: single-cycle ops plus the interrupt sequence
  // Ops are only taken in the idle state, so the vector load of
  // the last interrupt cycle can never meet a taken op
  always @(posedge clk) begin
    if (reset) begin
      stack_push_r <= 1'b0;
      program_counter <= `SFO_PC_RESET;
      accumulator <= `SFO_ACC_RESET;
      zero_flag <= 1'b0;
      file_we <= 1'b0;
      file_waddr <= {`SFO_FILE_AW{1'b0}};
      file_wdata <= `SFO_ZERO_BYTE;
      spr_we <= 1'b0;
      spr_addr <= {`SFO_SPR_AW{1'b0}};
      spr_wdata <= `SFO_ZERO_BYTE;
    end else begin
      // Write strobes last one cycle
      stack_push_r <= 1'b0;
      file_we <= 1'b0;
      spr_we <= 1'b0;
      if (take_swint) begin
        // Push happens before the vector load
        stack_push_r <= 1'b1;
      end else if (take_or_imm) begin
        accumulator <= or_res;
        zero_flag <= is_zero(or_res);
        program_counter <= pc_inc;
      end else if (take_or_reg) begin
        if (op_dest) begin
          // Result goes back to the file
          file_we <= 1'b1;
          file_waddr <= op_file_addr;
          file_wdata <= or_res;
        end else begin
          accumulator <= or_res;
        end
        zero_flag <= is_zero(or_res);
        program_counter <= pc_inc;
      end else if (take_store) begin
        // Flags and accumulator untouched
        spr_we <= 1'b1;
        spr_addr <= op_spr_addr;
        spr_wdata <= accumulator;
        program_counter <= pc_inc;
      end else if (state_r == ST_VECT) begin
        // Last interrupt cycle: jump after the push
        program_counter <= `SFO_VECTOR;
      end else begin
        // Unknown codes and idle cycles leave the counter alone
        program_counter <= program_counter;
      end
    end
  end
endmodule // sfo_exec

// >>> rtl/sfo_regs.vh
// Constants shared by the execution unit and its stack
`ifndef SFO_REGS_VH
`define SFO_REGS_VH
// ==========================================================
// Operation selects presented by the decode path
`define SFO_OP_NONE 3'h0
`define SFO_OP_SWINT 3'h1
`define SFO_OP_OR_IMM 3'h2
`define SFO_OP_OR_REG 3'h3
`define SFO_OP_SP_STORE 3'h4
// ==========================================================
// Widths and fixed values
`define SFO_PC_W 10
`define SFO_VECTOR 10'h001
`define SFO_PC_RESET 10'h000
`define SFO_ACC_RESET 8'h00
`define SFO_SWINT_CYCLES 2'h3
`define SFO_FILE_AW 6
`define SFO_SPR_AW 4
`define SFO_ZERO_BYTE 8'h00
`endif

// >>> rtl/sfo_return_stack.v
// Return-address stack that the software interrupt pushes into
`include "sfo_regs.vh"
module sfo_return_stack #(
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  clk,
  reset,
  push,
  push_addr,
  top_addr,
  level
);
  input wire clk;
  input wire reset;
  input wire push;
  input wire [`SFO_PC_W-1:0] push_addr;
  output reg [`SFO_PC_W-1:0] top_addr;
  output reg [PTR_W-1:0] level;

  // Storage array; wraps silently, overflow handling lives elsewhere
  reg [`SFO_PC_W-1:0] mem_r [0:DEPTH-1];

  // ==========================================================
  // Push path
  always @(posedge clk) begin
    if (reset) begin
      level <= {PTR_W{1'b0}};
      top_addr <= `SFO_PC_RESET;
    end else if (push) begin
      mem_r[level] <= push_addr;
      top_addr <= push_addr;
      level <= level + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sfo_return_stack

// >>> tb/sfo_exec_asserts.sv
// Concurrent checks on the execution unit ports
`include "sfo_regs.vh"
module sfo_exec_chk (
  input logic clk,
  input logic reset,
  input logic op_valid,
  input logic [2:0] op_sel,
  input logic [7:0] op_literal,
  input logic op_dest,
  input logic [7:0] file_rdata,
  input logic op_ready,
  input logic [9:0] program_counter,
  input logic [7:0] accumulator,
  input logic zero_flag,
  input logic file_we,
  input logic [7:0] file_wdata,
  input logic spr_we,
  input logic [7:0] spr_wdata,
  input logic [9:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Accepted operations, decoded once
  wire tk = op_valid && op_ready;
  wire sw = tk && op_sel == `SFO_OP_SWINT;
  wire ti = tk && op_sel == `SFO_OP_OR_IMM;
  wire tr = tk && op_sel == `SFO_OP_OR_REG;
  wire ts = tk && op_sel == `SFO_OP_SP_STORE;
  // Interrupt steps: two busy cycles, flags frozen throughout
  sequence s_busy; !op_ready [*2] ##1 op_ready; endsequence
  sequence s_hold; $stable({accumulator, zero_flag}) [*3]; endsequence
  chk_swint_push: assert property (sw |-> ##2
    stack_top == $past(program_counter, 2) + 10'h001) else $error("push");
  chk_swint_vector: assert property (sw |-> ##3
    program_counter == `SFO_VECTOR) else $error("vector");
  chk_swint_busy: assert property (sw |=> s_busy)
    else $error("busy");
  chk_swint_flags: assert property (sw |=> s_hold)
    else $error("flags");
  chk_or_imm: assert property (ti |=> accumulator ==
    ($past(accumulator) | $past(op_literal))) else $error("or imm");
  chk_or_zero: assert property (ti |=>
    zero_flag == (accumulator == 8'h00)) else $error("zero");
  chk_reg_zero: assert property (tr |=> zero_flag ==
    (($past(accumulator) | $past(file_rdata)) == 8'h00))
    else $error("reg zero");
  chk_or_reg_acc: assert property (tr && !op_dest |=> !file_we &&
    accumulator == ($past(accumulator) | $past(file_rdata)))
    else $error("reg to acc");
  chk_or_reg_wb: assert property (tr && op_dest |=> file_we &&
    file_wdata == ($past(accumulator) | $past(file_rdata))
    && $stable(accumulator)) else $error("write back");
  chk_store_page: assert property (ts |=> spr_we &&
    spr_wdata == $past(accumulator) && $stable({accumulator, zero_flag}))
    else $error("store");
endmodule // sfo_exec_chk
bind sfo_exec sfo_exec_chk u_chk (.*);

// >>> tb/tb.sv
// Self-checking bench for the execution unit
`include "sfo_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, op_valid = 0, op_dest = 0;
  logic [2:0] op_sel = 0;
  logic [7:0] op_literal = 0, file_rdata = 0;
  logic [5:0] op_file_addr = 0;
  logic [3:0] op_spr_addr = 0;
  wire op_ready, zero_flag, file_we, spr_we;
  wire [9:0] program_counter, stack_top;
  wire [7:0] accumulator, file_wdata, spr_wdata;
  wire [5:0] file_waddr;
  wire [3:0] spr_addr;
  wire [2:0] stack_level;
  logic [9:0] p;
  int n_fail = 0, checks_done = 0;
  sfo_exec u_sfo_exec (.clk, .reset, .op_valid, .op_sel, .op_literal,
    .op_file_addr, .op_dest, .op_spr_addr, .file_rdata, .op_ready,
    .program_counter, .accumulator, .zero_flag, .file_we, .file_waddr,
    .file_wdata, .spr_we, .spr_addr, .spr_wdata, .stack_top, .stack_level);
  initial forever #2 clk = ~clk;
  task chk(input logic [9:0] s, input logic [9:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One accepted operation; the byte doubles as operand and address.
  // The offer stays up until an edge at which op_ready stands high.
  task op(input logic [2:0] s, input logic [7:0] l, input logic d);
    @(posedge clk);
    op_valid <= 1;
    op_sel <= s;
    op_literal <= l;
    file_rdata <= l;
    op_file_addr <= l[5:0];
    op_spr_addr <= l[3:0];
    op_dest <= d;
    #1;
    while (op_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    op_valid <= 0;
    #1;
  endtask
  task t_or_imm;
    op(`SFO_OP_OR_IMM, 8'h00, 0);
    chk(zero_flag, 1);
    op(`SFO_OP_OR_IMM, 8'h50, 0);
    chk(accumulator, 10'h050);
    chk(zero_flag, 0);
    op(`SFO_OP_OR_IMM, 8'hAA, 0);
    chk(accumulator, 10'h0FA);
    chk(zero_flag, 0);
    chk(program_counter, 10'h003);
  endtask
  task t_or_reg;
    p = program_counter;
    op(`SFO_OP_OR_REG, 8'h05, 1);
    chk(file_we, 1);
    chk(file_waddr, 10'h005);
    chk(file_wdata, 10'h0FF);
    chk(accumulator, 10'h0FA);
    chk(program_counter, p + 10'h001);
    op(`SFO_OP_OR_REG, 8'h3F, 0);
    chk(accumulator, 10'h0FF);
    chk(file_we, 0);
  endtask
  // Store, then a code that must do nothing at all
  task t_store;
    op(`SFO_OP_SP_STORE, 8'h0F, 0);
    chk({spr_we, spr_addr}, 10'h01F);
    chk(spr_wdata, 10'h0FF);
    chk(accumulator, 10'h0FF);
    p = program_counter;
    op(`SFO_OP_NONE, 8'h0F, 1);
    chk({file_we, spr_we}, 10'h000);
    chk(program_counter, p);
  endtask
  task t_swint;
    p = program_counter;
    op(`SFO_OP_SWINT, 8'h00, 0);
    chk(op_ready, 0);
    @(posedge clk);
    #1 chk(stack_top, p + 10'h001);
    chk(stack_level, 10'h001);
    @(posedge clk);
    #1 chk(program_counter, `SFO_VECTOR);
    chk({op_ready, zero_flag, accumulator}, 10'h2FF);
    // A second interrupt, then an op offered while it is busy
    op(`SFO_OP_SWINT, 8'h00, 0);
    op(`SFO_OP_OR_IMM, 8'h00, 0);
    chk(stack_top, `SFO_VECTOR + 10'h001);
    chk(stack_level, 10'h002);
    chk(program_counter, `SFO_VECTOR + 10'h001);
  endtask
  // Mid-run reset, then a register OR whose result is zero
  task t_reset;
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    op(`SFO_OP_OR_REG, 8'h00, 1);
    chk(zero_flag, 1);
    chk({file_we, file_wdata}, 10'h100);
    chk(accumulator, 10'h000);
  endtask
  task report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    t_or_imm;
    t_or_reg;
    t_store;
    t_swint;
    t_reset;
    report_and_stop;
  end
  // Cut a hang short
  initial begin
    #20000;
    n_fail++;
    report_and_stop;
  end
endmodule // tb
